/* File: verilog/pmbus_fault_pkg.sv */
// Behaviour
// - current warn limit: zero exponent, 11-bit mantissa
// - current warn limit loads channel maximum current
// - nonzero exponent write discarded, comm fault, alert
// - page 00h A, 01h B, FFh both
// - temperature above fault limit raises fault
// - thermal fault shuts down, flags, alerts
// - thermal action accepts 80h latch, C0h restart
// - latch clears on enable toggle or bias
// - shared commands ignore page selection
// - invalid action code discarded, comm fault, alert
// - warn limit flags and alerts, no shutdown
// - warn limit resets to 105 degrees
// - input limit rejects mantissa above 31
// - input overvoltage sets other, input flags, alert
// - input action fixed 00h, keeps converting
package pmbus_fault_pkg;
  // bus address of this device
  localparam logic [6:0] BUS_ADDR = 7'h58;
  // command codes
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_OCW = 8'h4a;
  localparam logic [7:0] CMD_OTF = 8'h4f;
  localparam logic [7:0] CMD_OTA = 8'h50;
  localparam logic [7:0] CMD_OTW = 8'h51;
  localparam logic [7:0] CMD_VINOV = 8'h55;
  localparam logic [7:0] CMD_VINA = 8'h56;
  // page selections
  localparam logic [7:0] PAGE_A = 8'h00;
  localparam logic [7:0] PAGE_B = 8'h01;
  localparam logic [7:0] PAGE_ALL = 8'hff;
  // exponent field position in the high data byte
  localparam int EXP_HI_LSB = 3;
  // action codes
  localparam logic [7:0] ACT_LATCH = 8'h80;
  localparam logic [7:0] ACT_RESTART = 8'hc0;
  localparam logic [7:0] VIN_ACT_FIXED = 8'h00;
  // reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] OTA_RST = 8'h80;
  localparam logic [10:0] OTW_RST = 11'h069;
  localparam logic [10:0] TEMP_FAULT_DEFAULT_SELECT_0 = 11'h07d;
  localparam logic [10:0] TEMP_FAULT_DEFAULT_SELECT_1 = 11'h096;
  localparam logic [10:0] VIN_RST = 11'h00e;
  localparam logic [10:0] VIN_MAN_MAX = 11'h01f;
  // status bit positions
  localparam int SB_TEMP = 2;
  localparam int SB_CML = 1;
  localparam int SB_OTHER = 0;
  localparam int SW_INPUT = 5;
  localparam int ST_THERMAL_FAULT_FLAG = 7;
  localparam int ST_OT_WARN = 6;
  localparam int SI_VIN_OV = 7;
  localparam int SC_INVALID = 6;
  // alert mask / event positions
  localparam int EV_CML = 0;
  localparam int EV_OTF = 1;
  localparam int EV_OTW = 2;
  localparam int EV_VIN = 3;
endpackage : pmbus_fault_pkg

/* File: verilog/pmbus_serial_link.sv */
`timescale 1ns/1ps
// serial byte engine: start/stop, address match, byte shift, ack
module pmbus_serial_link (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic [7:0] i_tx_byte,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_start,
  output logic o_stop,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_tx_taken
);
  // bit-level phases
  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_ACK_ADDR, L_RX, L_ACK_RX, L_TX, L_ACK_TX, L_TX_NEXT
  } link_state_t;

  // all state of the engine
  typedef struct packed {
    link_state_t st;
    logic [7:0] sh;
    logic [2:0] bits;
    logic rd;
    logic ack_on;
    logic oe;
    logic scl_s1, scl_s2, scl_prev;
    logic sda_s1, sda_s2, sda_prev;
    logic start, stop, rx_valid, tx_taken;
    logic [7:0] rx_byte;
  } link_t;

  link_t r_reg; // registered state
  link_t r_next; // next state
  logic rise, fall, start_c, stop_c; // bus events
  logic [7:0] full; // byte with the newest bit

  // bus event detection on synchronised lines
  always_comb begin
    rise = !r_reg.scl_prev && r_reg.scl_s2;
    fall = r_reg.scl_prev && !r_reg.scl_s2;
    start_c = r_reg.scl_s2 && r_reg.scl_prev && r_reg.sda_prev
      && !r_reg.sda_s2;
    stop_c = r_reg.scl_s2 && r_reg.scl_prev && !r_reg.sda_prev
      && r_reg.sda_s2;
    full = {r_reg.sh[6:0], r_reg.sda_s2};
  end

  // next-state logic of the engine
  always_comb begin
    r_next = r_reg;
    // two-flop synchronisers, first stage read only here
    r_next.scl_s1 = i_scl;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_prev = r_reg.scl_s2;
    r_next.sda_s1 = i_sda_in;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_prev = r_reg.sda_s2;
    r_next.start = 1'b0;
    r_next.stop = 1'b0;
    r_next.rx_valid = 1'b0;
    r_next.tx_taken = 1'b0;
    if (start_c) begin // start or repeated start
      r_next.st = L_ADDR;
      r_next.bits = 3'd0;
      r_next.oe = 1'b0;
      r_next.start = 1'b1;
    end else if (stop_c) begin // stop ends everything
      r_next.st = L_IDLE;
      r_next.oe = 1'b0;
      r_next.stop = 1'b1;
    end else if (rise) begin // sample on rising clock
      case (r_reg.st)
        L_ADDR, L_RX: begin
          r_next.sh = full;
          r_next.bits = r_reg.bits + 3'd1;
          if (r_reg.bits == 3'd7) begin
            r_next.ack_on = 1'b0;
            if (r_reg.st == L_RX) begin
              r_next.rx_byte = full;
              r_next.rx_valid = 1'b1;
              r_next.st = L_ACK_RX;
            end else if (full[7:1] == pmbus_fault_pkg::BUS_ADDR) begin
              r_next.rd = full[0];
              r_next.st = L_ACK_ADDR;
            end else begin
              r_next.st = L_IDLE;
            end
          end
        end
        L_TX: begin
          r_next.bits = r_reg.bits + 3'd1;
          if (r_reg.bits == 3'd7) begin
            r_next.st = L_ACK_TX;
          end
        end
        L_ACK_TX: begin // master nack ends the read
          r_next.st = r_reg.sda_s2 ? L_IDLE : L_TX_NEXT;
        end
        default: begin
        end
      endcase
    end else if (fall) begin // drive on falling clock
      case (r_reg.st)
        L_ACK_ADDR, L_ACK_RX: begin
          if (!r_reg.ack_on) begin // pull low for ack
            r_next.ack_on = 1'b1;
            r_next.oe = 1'b1;
          end else begin
            r_next.ack_on = 1'b0;
            r_next.oe = 1'b0;
            r_next.bits = 3'd0;
            if (r_reg.st == L_ACK_ADDR && r_reg.rd) begin
              r_next.sh = i_tx_byte;
              r_next.oe = !i_tx_byte[7];
              r_next.tx_taken = 1'b1;
              r_next.st = L_TX;
            end else begin
              r_next.st = L_RX;
            end
          end
        end
        L_TX: begin // next data bit, msb first
          r_next.sh = {r_reg.sh[6:0], 1'b0};
          r_next.oe = !r_reg.sh[6];
        end
        L_ACK_TX: begin
          r_next.oe = 1'b0;
        end
        L_TX_NEXT: begin // load the following byte
          r_next.sh = i_tx_byte;
          r_next.oe = !i_tx_byte[7];
          r_next.tx_taken = 1'b1;
          r_next.bits = 3'd0;
          r_next.st = L_TX;
        end
        default: begin
        end
      endcase
    end
    if (!i_rst_n) begin // synchronous reset
      r_next = '0;
    end
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    r_reg <= r_next;
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = r_reg.oe;
  assign o_start = r_reg.start;
  assign o_stop = r_reg.stop;
  assign o_rx_valid = r_reg.rx_valid;
  assign o_rx_byte = r_reg.rx_byte;
  assign o_tx_taken = r_reg.tx_taken;
endmodule : pmbus_serial_link

/* File: verilog/pmbus_fault_limit_response_bank.sv */
`timescale 1ns/1ps
// fault and warning limit bank behind the serial management bus
module pmbus_fault_limit_response_bank (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_alert_line_out,
  output logic o_alert_line_oe,
  input wire logic [10:0] i_channel_max_current_a,
  input wire logic [10:0] i_channel_max_current_b,
  input wire logic i_temp_fault_default_select,
  input wire logic i_restore_defaults,
  input wire logic [10:0] i_temp_a,
  input wire logic [10:0] i_temp_b,
  input wire logic [10:0] i_vin_volts,
  input wire logic [3:0] i_alert_mask_reg,
  input wire logic i_status_clear,
  input wire logic [1:0] i_channel_enable_pin,
  input wire logic [1:0] i_operation_on,
  input wire logic i_onoff_use_pin,
  input wire logic i_onoff_use_cmd,
  input wire logic i_bias_supply_pin,
  output logic [1:0] o_channel_shutdown,
  output logic [7:0] o_status_byte,
  output logic [15:0] o_status_word,
  output logic [7:0] o_status_temp,
  output logic [7:0] o_status_input,
  output logic [7:0] o_comm_fault_status
);
  // all state of the bank
  typedef struct packed {
    logic [7:0] page;
    logic [1:0][10:0] ocw_mantissa;
    logic [1:0][10:0] temp_fault_mantissa;
    logic [1:0][10:0] temp_warn_mantissa;
    logic [7:0] temp_fault_action_code;
    logic [10:0] input_ov_mantissa;
    logic [7:0] cmd, lo, hi;
    logic [2:0] count;
    logic rd_hi;
    logic cml, thermal_fault_flag, temp_warn_flag, input_ov_flag;
    logic [1:0] latch;
    logic [1:0] shut;
    logic alert;
    logic [1:0] en_s1, en_s2, en_prev;
    logic bias_s1, bias_s2;
    logic [1:0] on_prev;
  } bank_t;

  bank_t r_reg; // registered state
  bank_t r_next; // next state
  logic link_start, link_stop, rx_valid, tx_taken; // engine events
  logic [7:0] rx_byte; // received byte
  logic [7:0] tx_byte; // byte offered for reading
  logic [15:0] rd_word; // selected register value
  logic sel_b; // page points at channel b
  logic [1:0][10:0] temp; // sensed temperature per channel
  logic [1:0] ot_ch, warn_ch; // per-channel comparisons
  logic ot_now, warn_now, vin_now; // live conditions
  logic commit, size_ok, bad, bad_all, good; // write checking
  logic word_cmd, byte_cmd; // command width classes
  logic [1:0] wr_ch; // channels reached by a paged write
  logic [1:0] en_fall, on_fall; // off edges of enable controls
  logic [3:0] flags_next; // sticky events after update

  // serial byte engine
  pmbus_serial_link u_link (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_scl(i_scl),
    .i_sda_in(i_sda_in),
    .i_tx_byte(tx_byte),
    .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe),
    .o_start(link_start),
    .o_stop(link_stop),
    .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte),
    .o_tx_taken(tx_taken)
  );

  // read mux and write classification
  always_comb begin
    sel_b = (r_reg.page == pmbus_fault_pkg::PAGE_B);
    rd_word = 16'h0000;
    word_cmd = 1'b0;
    byte_cmd = 1'b0;
    bad = 1'b1;
    case (r_reg.cmd)
      pmbus_fault_pkg::CMD_PAGE: begin
        rd_word = {8'h00, r_reg.page};
        byte_cmd = 1'b1;
        bad = !(r_reg.lo == pmbus_fault_pkg::PAGE_A ||
          r_reg.lo == pmbus_fault_pkg::PAGE_B ||
          r_reg.lo == pmbus_fault_pkg::PAGE_ALL);
      end
      pmbus_fault_pkg::CMD_OCW: begin // exponent reads zero
        rd_word = {5'h00, r_reg.ocw_mantissa[sel_b]};
        word_cmd = 1'b1;
        bad = (r_reg.hi[7:3] != 5'h00);
      end
      pmbus_fault_pkg::CMD_OTF: begin
        rd_word = {5'h00, r_reg.temp_fault_mantissa[sel_b]};
        word_cmd = 1'b1;
        bad = (r_reg.hi[7:3] != 5'h00);
      end
      pmbus_fault_pkg::CMD_OTA: begin
        rd_word = {8'h00, r_reg.temp_fault_action_code};
        byte_cmd = 1'b1;
        bad = !(r_reg.lo == pmbus_fault_pkg::ACT_LATCH ||
          r_reg.lo == pmbus_fault_pkg::ACT_RESTART);
      end
      pmbus_fault_pkg::CMD_OTW: begin
        rd_word = {5'h00, r_reg.temp_warn_mantissa[sel_b]};
        word_cmd = 1'b1;
        bad = (r_reg.hi[7:3] != 5'h00);
      end
      pmbus_fault_pkg::CMD_VINOV: begin
        rd_word = {5'h00, r_reg.input_ov_mantissa};
        word_cmd = 1'b1;
        bad = (r_reg.hi[7:3] != 5'h00) ||
          ({r_reg.hi[2:0], r_reg.lo} > pmbus_fault_pkg::VIN_MAN_MAX);
      end
      pmbus_fault_pkg::CMD_VINA: begin // read-only fixed action
        rd_word = {8'h00, pmbus_fault_pkg::VIN_ACT_FIXED};
        byte_cmd = 1'b1;
        bad = 1'b1;
      end
      default: begin // unsupported command
        bad = 1'b1;
      end
    endcase
    tx_byte = r_reg.rd_hi ? rd_word[15:8] : rd_word[7:0];
    commit = link_stop && (r_reg.count >= 3'd2);
    size_ok = (word_cmd && r_reg.count == 3'd3) ||
      (byte_cmd && r_reg.count == 3'd2);
    bad_all = !size_ok || bad;
    good = commit && !bad_all;
    wr_ch[0] = (r_reg.page == pmbus_fault_pkg::PAGE_ALL) || !sel_b;
    wr_ch[1] = (r_reg.page == pmbus_fault_pkg::PAGE_ALL) || sel_b;
  end

  // per-channel threshold comparisons
  always_comb begin
    temp[0] = i_temp_a;
    temp[1] = i_temp_b;
    for (int c = 0; c < 2; c++) begin
      ot_ch[c] = $signed(temp[c]) >
        $signed(r_reg.temp_fault_mantissa[c]);
      warn_ch[c] = $signed(temp[c]) >
        $signed(r_reg.temp_warn_mantissa[c]);
    end
    ot_now = |ot_ch;
    warn_now = |warn_ch;
    vin_now = i_vin_volts > r_reg.input_ov_mantissa;
    en_fall = r_reg.en_prev & ~r_reg.en_s2;
    on_fall = r_reg.on_prev & ~i_operation_on;
  end

  // next-state logic of the bank
  always_comb begin
    r_next = r_reg;
    // pin synchronisers
    r_next.en_s1 = i_channel_enable_pin;
    r_next.en_s2 = r_reg.en_s1;
    r_next.en_prev = r_reg.en_s2;
    r_next.bias_s1 = i_bias_supply_pin;
    r_next.bias_s2 = r_reg.bias_s1;
    r_next.on_prev = i_operation_on;
    // transaction tracking
    if (link_start) begin
      r_next.count = 3'd0;
      r_next.rd_hi = 1'b0;
    end else if (rx_valid) begin
      case (r_reg.count)
        3'd0: r_next.cmd = rx_byte;
        3'd1: r_next.lo = rx_byte;
        3'd2: r_next.hi = rx_byte;
        default: begin
        end
      endcase
      if (r_reg.count != 3'd7) begin
        r_next.count = r_reg.count + 3'd1;
      end
    end
    if (tx_taken) begin // low byte first, then high
      r_next.rd_hi = !r_reg.rd_hi;
    end
    // accepted writes
    if (good) begin
      case (r_reg.cmd)
        pmbus_fault_pkg::CMD_PAGE: r_next.page = r_reg.lo;
        pmbus_fault_pkg::CMD_OTA: begin // shared, page ignored
          r_next.temp_fault_action_code = r_reg.lo;
        end
        pmbus_fault_pkg::CMD_VINOV: begin
          r_next.input_ov_mantissa = {r_reg.hi[2:0], r_reg.lo};
        end
        default: begin // paged word limits
          for (int c = 0; c < 2; c++) begin
            if (wr_ch[c]) begin
              if (r_reg.cmd == pmbus_fault_pkg::CMD_OCW) begin
                r_next.ocw_mantissa[c] = {r_reg.hi[2:0], r_reg.lo};
              end else if (r_reg.cmd == pmbus_fault_pkg::CMD_OTF) begin
                r_next.temp_fault_mantissa[c] = {r_reg.hi[2:0], r_reg.lo};
              end else if (r_reg.cmd == pmbus_fault_pkg::CMD_OTW) begin
                r_next.temp_warn_mantissa[c] = {r_reg.hi[2:0], r_reg.lo};
              end
            end
          end
        end
      endcase
    end
    // sticky flags, a new event wins over the clear
    r_next.cml = (r_reg.cml && !i_status_clear) ||
      (commit && bad_all);
    r_next.thermal_fault_flag = (r_reg.thermal_fault_flag &&
      !i_status_clear) || ot_now;
    r_next.temp_warn_flag = (r_reg.temp_warn_flag &&
      !i_status_clear) || warn_now;
    r_next.input_ov_flag = (r_reg.input_ov_flag &&
      !i_status_clear) || vin_now;
    // latch-off and restart handling, both channels shut down
    for (int c = 0; c < 2; c++) begin
      r_next.latch[c] = (r_reg.latch[c] &&
        !((i_onoff_use_pin && en_fall[c]) ||
          (i_onoff_use_cmd && on_fall[c]) || !r_reg.bias_s2)) ||
        (ot_now && r_reg.temp_fault_action_code ==
          pmbus_fault_pkg::ACT_LATCH);
      r_next.shut[c] = r_next.latch[c] || (ot_now &&
        r_reg.temp_fault_action_code ==
          pmbus_fault_pkg::ACT_RESTART);
    end
    // alert unless masked
    flags_next = 4'h0;
    flags_next[pmbus_fault_pkg::EV_CML] = r_next.cml;
    flags_next[pmbus_fault_pkg::EV_OTF] = r_next.thermal_fault_flag;
    flags_next[pmbus_fault_pkg::EV_OTW] = r_next.temp_warn_flag;
    flags_next[pmbus_fault_pkg::EV_VIN] = r_next.input_ov_flag;
    r_next.alert = |(flags_next & ~i_alert_mask_reg);
    // reset and restore-defaults loading
    if (!i_rst_n) begin
      r_next = '0;
      r_next.page = pmbus_fault_pkg::PAGE_RST;
    end
    if (!i_rst_n || i_restore_defaults) begin
      r_next.ocw_mantissa[0] = i_channel_max_current_a;
      r_next.ocw_mantissa[1] = i_channel_max_current_b;
      for (int c = 0; c < 2; c++) begin
        r_next.temp_fault_mantissa[c] = i_temp_fault_default_select ?
          pmbus_fault_pkg::TEMP_FAULT_DEFAULT_SELECT_1 :
          pmbus_fault_pkg::TEMP_FAULT_DEFAULT_SELECT_0;
        r_next.temp_warn_mantissa[c] = pmbus_fault_pkg::OTW_RST;
      end
      r_next.temp_fault_action_code = pmbus_fault_pkg::OTA_RST;
      r_next.input_ov_mantissa = pmbus_fault_pkg::VIN_RST;
    end
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    r_reg <= r_next;
  end

  // status and pin outputs straight from state
  always_comb begin
    o_status_byte = 8'h00;
    o_status_byte[pmbus_fault_pkg::SB_TEMP] =
      r_reg.thermal_fault_flag || r_reg.temp_warn_flag;
    o_status_byte[pmbus_fault_pkg::SB_CML] = r_reg.cml;
    o_status_byte[pmbus_fault_pkg::SB_OTHER] = r_reg.input_ov_flag;
    o_status_word = {8'h00, o_status_byte};
    o_status_word[8 + pmbus_fault_pkg::SW_INPUT] = r_reg.input_ov_flag;
    o_status_temp = 8'h00;
    o_status_temp[pmbus_fault_pkg::ST_THERMAL_FAULT_FLAG] = r_reg.thermal_fault_flag;
    o_status_temp[pmbus_fault_pkg::ST_OT_WARN] = r_reg.temp_warn_flag;
    o_status_input = 8'h00;
    o_status_input[pmbus_fault_pkg::SI_VIN_OV] = r_reg.input_ov_flag;
    o_comm_fault_status = 8'h00;
    o_comm_fault_status[pmbus_fault_pkg::SC_INVALID] = r_reg.cml;
  end
  assign o_alert_line_out = 1'b0;
  assign o_alert_line_oe = r_reg.alert;
  assign o_channel_shutdown = r_reg.shut;

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_exp_reject: assert property (
    (commit && word_cmd && r_reg.hi[7:3] != 5'h00) |=>
      r_reg.cml && $stable(r_reg.ocw_mantissa) && o_status_word[1])
    else $error("bad exponent write not rejected");
  a_ocw_restore: assert property (
    (i_restore_defaults && !$past(!i_rst_n)) |=>
      r_reg.ocw_mantissa[1] == $past(i_channel_max_current_b))
    else $error("current warn limit not restored");
  a_ot_latch_off: assert property (
    (ot_now && r_reg.temp_fault_action_code == 8'h80) |=>
      o_channel_shutdown == 2'b11 && o_status_temp[7] && o_status_byte[2])
    else $error("thermal fault did not latch off");
  a_action_codes: assert property (
    r_reg.temp_fault_action_code == 8'h80 ||
      r_reg.temp_fault_action_code == 8'hc0)
    else $error("illegal thermal action code held");
  a_warn_no_shut: assert property (
    (warn_now && !ot_now && r_reg.latch == 2'b00) |=>
      o_channel_shutdown == 2'b00 && o_status_temp[6])
    else $error("warning shut down or not flagged");
  a_alert_sticky: assert property (
    (o_alert_line_oe && !i_status_clear && i_alert_mask_reg == 4'h0) |=>
      o_alert_line_oe)
    else $error("alert dropped without clear");
  a_vin_range: assert property (
    (commit && r_reg.cmd == 8'h55 && r_reg.hi[2:0] == 3'h0 &&
      r_reg.lo > 8'h1f) |=> $stable(r_reg.input_ov_mantissa) && r_reg.cml)
    else $error("input limit above 31 accepted");
  a_vin_flags: assert property (
    vin_now |=> o_status_input[7] && o_status_word[13] && o_status_byte[0])
    else $error("input overvoltage not flagged");
  a_page_route: assert property (
    (good && r_reg.cmd == 8'h51 && r_reg.page == 8'h00) |=>
      $stable(r_reg.temp_warn_mantissa[1]))
    else $error("page a write reached channel b");
  a_latch_clear: assert property (
    (!r_reg.bias_s2 && !ot_now) |=> r_reg.latch == 2'b00)
    else $error("bias loss did not clear latch");
endmodule : pmbus_fault_limit_response_bank

/* File: verif/pmbus_host_model.sv */
`timescale 1ns/1ps
// bus host: bit-bangs clock and open-drain data
module pmbus_host_model (
  input wire logic i_clk_sys,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // clock idles high, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // one bus bit: clock low 5 cycles, high 3 (200 ns)
  task automatic bit_io(input logic b, output logic r);
    @(posedge i_clk_sys);
    o_sda_low <= ~b;
    repeat (4) @(posedge i_clk_sys);
    o_scl <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    r = i_sda;
    @(posedge i_clk_sys);
    o_scl <= 1'b0;
  endtask : bit_io
  // byte out msb first, then release for the ack
  task automatic tx(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
  endtask : tx
  // byte in, then ack, or nack on the last byte
  task automatic rx(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, r);
  endtask : rx
  // start: data falls while clock high; waits out an ack first
  task automatic start();
    @(posedge i_clk_sys);
    o_sda_low <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    o_scl <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    o_sda_low <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    o_scl <= 1'b0;
  endtask : start
  // stop: data rises while clock high, then idle gap
  task automatic stop();
    @(posedge i_clk_sys);
    o_sda_low <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    o_scl <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    o_sda_low <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
  endtask : stop
  // write: address, command, then n data bytes low first
  task automatic wr(input logic [7:0] c, input int n,
                    input logic [15:0] d);
    start();
    tx({pmbus_fault_pkg::BUS_ADDR, 1'b0});
    tx(c);
    for (int i = 0; i < n; i++) tx(d[8*i +: 8]);
    stop(); // the write only commits on the stop
  endtask : wr
  // read: command, repeated start, n bytes, nack the last
  task automatic rd(input logic [7:0] c, input int n,
                    output logic [15:0] d);
    d = 16'h0000;
    start();
    tx({pmbus_fault_pkg::BUS_ADDR, 1'b0});
    tx(c);
    start();
    tx({pmbus_fault_pkg::BUS_ADDR, 1'b1});
    for (int i = 0; i < n; i++) rx(i == n - 1, d[8*i +: 8]);
    stop();
  endtask : rd
endmodule : pmbus_host_model

/* File: verif/tb_pmbus_fault_limit_response_bank.sv */
`timescale 1ns/1ps
// bench: register rows through the bus, then event cases
module tb_pmbus_fault_limit_response_bank;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    err_total++; $display("Error %0t: got %h want %h", $time, a, b); \
    end end
  typedef struct packed {
    logic [7:0] c;
    logic [1:0] nw;
    logic [15:0] d;
    logic [1:0] nr;
    logic [15:0] e;
    logic f;
  } row_t;
  // command, bytes written, data, bytes read, readback, fault flag
  row_t rows [21] = '{
    '{8'h4a,2'h0,16'h0,2'h2,16'h002a,1'h0},
    '{8'h4f,2'h0,16'h0,2'h2,16'h007d,1'h0},
    '{8'h51,2'h0,16'h0,2'h2,16'h0069,1'h0},
    '{8'h50,2'h0,16'h0,2'h1,16'h0080,1'h0},
    '{8'h56,2'h0,16'h0,2'h1,16'h0000,1'h0},
    '{8'h51,2'h2,16'h0064,2'h2,16'h0064,1'h0},
    '{8'h51,2'h2,16'h0864,2'h2,16'h0064,1'h1},
    '{8'h4a,2'h2,16'hf805,2'h2,16'h002a,1'h1},
    '{8'h55,2'h2,16'h001f,2'h2,16'h001f,1'h0},
    '{8'h55,2'h2,16'h0020,2'h2,16'h001f,1'h1},
    '{8'h50,2'h1,16'h00c0,2'h1,16'h00c0,1'h0},
    '{8'h50,2'h1,16'h0055,2'h1,16'h00c0,1'h1},
    '{8'h56,2'h1,16'h0012,2'h1,16'h0000,1'h1},
    '{8'h00,2'h1,16'h0001,2'h1,16'h0001,1'h0},
    '{8'h4a,2'h0,16'h0,2'h2,16'h0017,1'h0},
    '{8'h00,2'h1,16'h0002,2'h1,16'h0001,1'h1},
    '{8'h50,2'h0,16'h0,2'h1,16'h00c0,1'h0},
    '{8'h00,2'h1,16'h00ff,2'h1,16'h00ff,1'h0},
    '{8'h4a,2'h2,16'h0033,2'h2,16'h0033,1'h0},
    '{8'h00,2'h1,16'h0001,2'h1,16'h0001,1'h0},
    '{8'h4a,2'h0,16'h0,2'h2,16'h0033,1'h0}};
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_scl, sda_low, o_sda_out, o_sda_oe, o_alert_line_out;
  logic o_alert_line_oe, i_restore_defaults = 1'b0;
  logic i_status_clear = 1'b0, i_bias_supply_pin = 1'b1;
  logic [10:0] i_temp_a = 11'h019, i_temp_b = 11'h019;
  logic [10:0] i_vin_volts = 11'h00c;
  logic [3:0] i_alert_mask_reg = 4'h0;
  logic [1:0] i_channel_enable_pin = 2'h3, o_channel_shutdown;
  logic [1:0] i_operation_on = 2'h3;
  logic [7:0] o_status_byte, o_status_temp, o_status_input;
  logic [7:0] o_comm_fault_status;
  logic [15:0] o_status_word, got;
  int err_total = 0;
  int cmp_count = 0;
  // wired data line with pull-up
  wire i_sda_in = ~(sda_low | o_sda_oe);
  pmbus_host_model pmbus_host_model_inst (.i_clk_sys, .i_sda(i_sda_in),
    .o_scl(i_scl), .o_sda_low(sda_low));
  pmbus_fault_limit_response_bank pmbus_fault_limit_response_bank_inst (
    .i_clk_sys, .i_rst_n, .i_scl, .i_sda_in, .o_sda_out, .o_sda_oe,
    .o_alert_line_out, .o_alert_line_oe,
    .i_channel_max_current_a(11'h02a), .i_channel_max_current_b(11'h017),
    .i_temp_fault_default_select(1'b0), .i_restore_defaults,
    .i_temp_a, .i_temp_b, .i_vin_volts, .i_alert_mask_reg,
    .i_status_clear, .i_channel_enable_pin, .i_operation_on,
    .i_onoff_use_pin(1'b1), .i_onoff_use_cmd(1'b0), .i_bias_supply_pin,
    .o_channel_shutdown, .o_status_byte, .o_status_word, .o_status_temp,
    .o_status_input, .o_comm_fault_status);
  // 40 MHz clock
  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // let n edges pass, then step past them
  task automatic w(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : w
  // pulse the sticky-flag clear
  task automatic clear();
    @(posedge i_clk_sys) i_status_clear <= 1'b1;
    @(posedge i_clk_sys) i_status_clear <= 1'b0;
    w(2);
  endtask : clear
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // hang guard
  initial begin
    w(90000);
    err_total++;
    tally_and_finish();
  end
  initial begin
    w(12);
    @(posedge i_clk_sys) i_rst_n <= 1'b1;
    w(4);
    `CHK({o_alert_line_oe, o_channel_shutdown, o_status_word}, 19'h0)
    `CHK({o_sda_out, o_alert_line_out}, 2'h0)
    $display("reset test done");
    foreach (rows[k]) begin
      if (rows[k].nw != 2'h0)
        pmbus_host_model_inst.wr(rows[k].c, rows[k].nw, rows[k].d);
      pmbus_host_model_inst.rd(rows[k].c, rows[k].nr, got);
      #1;
      `CHK(got, rows[k].e)
      `CHK({o_alert_line_oe, o_status_byte[1], o_comm_fault_status[6]}, {3{rows[k].f}})
      clear();
      $display("row %0d done", k);
    end
    // warning on channel A, then masked
    @(posedge i_clk_sys) i_temp_a <= 11'h065;
    w(4);
    `CHK({o_status_temp[6], o_status_byte[2], o_alert_line_oe, o_channel_shutdown}, 5'h1c)
    @(posedge i_clk_sys) i_temp_a <= 11'h019;
    w(4);
    `CHK({o_status_temp[6], o_alert_line_oe}, 2'h3)
    @(posedge i_clk_sys) i_alert_mask_reg <= 4'h4;
    @(posedge i_clk_sys) i_temp_a <= 11'h065;
    clear();
    w(3);
    `CHK({o_status_temp[6], o_alert_line_oe}, 2'h2)
    @(posedge i_clk_sys) i_temp_a <= 11'h019;
    clear();
    $display("warning test done");
    // fault on B with restart action
    @(posedge i_clk_sys) i_temp_b <= 11'h082;
    w(4);
    `CHK({o_status_temp[7], o_status_byte[2], o_channel_shutdown}, 4'hf)
    @(posedge i_clk_sys) i_temp_b <= 11'h019;
    w(4);
    `CHK(o_channel_shutdown, 2'h0)
    // latch action holds until enable pin falls
    pmbus_host_model_inst.wr(8'h50, 1, 16'h0080);
    @(posedge i_clk_sys) i_temp_b <= 11'h082;
    w(4);
    @(posedge i_clk_sys) i_temp_b <= 11'h019;
    i_operation_on <= 2'h0; // on-bit drop ignored in pin mode
    w(8);
    `CHK(o_channel_shutdown, 2'h3)
    @(posedge i_clk_sys) i_channel_enable_pin <= 2'h2;
    w(8);
    `CHK(o_channel_shutdown, 2'h2)
    @(posedge i_clk_sys) i_bias_supply_pin <= 1'b0;
    w(8);
    `CHK(o_channel_shutdown, 2'h0)
    @(posedge i_clk_sys) i_channel_enable_pin <= 2'h3;
    i_operation_on <= 2'h3;
    i_bias_supply_pin <= 1'b1;
    clear();
    $display("fault test done");
    // input overvoltage flags only
    @(posedge i_clk_sys) i_vin_volts <= 11'h020;
    w(4);
    `CHK({o_status_input[7], o_status_byte[0], o_status_word[13], o_channel_shutdown}, 5'h1c)
    @(posedge i_clk_sys) i_vin_volts <= 11'h00c;
    clear();
    // restore reloads channel B current warning
    @(posedge i_clk_sys) i_restore_defaults <= 1'b1;
    @(posedge i_clk_sys) i_restore_defaults <= 1'b0;
    pmbus_host_model_inst.rd(8'h4a, 2, got);
    `CHK(got, 16'h0017)
    $display("event tests done");
    tally_and_finish();
  end
endmodule : tb_pmbus_fault_limit_response_bank
